// ### design/ivfr_defs.svh
// Offsets, field positions and reset values of the input voltage fault response block.
`ifndef IVFR_DEFS_SVH
`define IVFR_DEFS_SVH

`define IVFR_CMD_HIGH_WARN     8'h57
`define IVFR_CMD_LOW_WARN      8'h58
`define IVFR_CMD_LOW_TRIP      8'h59
`define IVFR_CMD_LOW_ACTION    8'h5A

`define IVFR_RESP_MSB          7
`define IVFR_RESP_LSB          6
`define IVFR_RETRY_MSB         5
`define IVFR_RETRY_LSB         3
`define IVFR_DELAY_MSB         2
`define IVFR_DELAY_LSB         0

`define IVFR_RETRY_NONE        3'h0
`define IVFR_RETRY_FOREVER     3'h7

`define IVFR_HIGH_WARN_RST     16'h0000
`define IVFR_LOW_WARN_RST      16'h0000
`define IVFR_LOW_TRIP_RST      16'h0000
`define IVFR_LOW_ACTION_RST    8'h00

`endif

// ### design/ivfr_pkg.sv
// Types and the linear-format helper shared by the input voltage fault response block.
package ivfr_pkg;

  typedef enum logic [1:0] {
    IVFR_RESP_IGNORE   = 2'b00,
    IVFR_RESP_DELAY    = 2'b01,
    IVFR_RESP_DISABLE  = 2'b10,
    IVFR_RESP_RESUME   = 2'b11
  } ivfr_resp_e;

  typedef enum logic [2:0] {
    IVFR_ST_OFF     = 3'b000,
    IVFR_ST_RUN     = 3'b001,
    IVFR_ST_GRACE   = 3'b010,
    IVFR_ST_BACKOFF = 3'b011,
    IVFR_ST_HOLD    = 3'b100,
    IVFR_ST_LATCHED = 3'b101
  } ivfr_state_e;

  typedef logic [47:0] ivfr_fix_t;

  // Linear value (5-bit signed exponent, 11-bit signed mantissa) to fixed point with
  // 16 fraction bits; negative values clamp to zero since input voltage cannot be below it.
  function automatic ivfr_fix_t ivfr_lin_to_fix(input logic [15:0] lin);
    logic [4:0]  shift;
    ivfr_fix_t   mant;
    shift = lin[15:11] + 5'h10;
    mant  = {37'h0, lin[10:0]};
    if (lin[10]) begin
      return 48'h0;
    end
    return mant << shift;
  endfunction

endpackage

// ### design/ivfr_tmr_if.sv
// Start and done signals between the fault sequencer and its delay timer.
`timescale 1ns/10ps
interface ivfr_tmr_if;
  logic       start;
  logic [2:0] exp_sel;
  logic       done;

  modport ctrl (output start, output exp_sel, input done);
  modport tmr  (input start, input exp_sel, output done);
endinterface // ivfr_tmr_if

// ### design/ivfr_sync3.sv
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps
module ivfr_sync3 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;

  // The output only follows when stages two and three match, filtering a single glitch.
  always_comb begin
    next_dout = (s2 == s3) ? s3 : dout;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule // ivfr_sync3

// ### design/ivfr_unit_timer.sv
// Delay timer counting two to the power of the delay field in units of a given length.
`timescale 1ns/10ps
module ivfr_unit_timer (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic [15:0] unit_cycles,
  ivfr_tmr_if.tmr     tif
);
  logic        busy;
  logic [15:0] cyc;
  logic [8:0]  units_left;
  logic        next_busy;
  logic [15:0] next_cyc;
  logic [8:0]  next_units_left;
  logic        next_done;
  logic [15:0] unit_len;

  // A zero unit length would never tick, so it is treated as one cycle.
  assign unit_len = (unit_cycles == 16'h0000) ? 16'h0001 : unit_cycles;

  // Units are 1 shl field, so field 0 gives 1 unit and field 7 gives 128 units.
  always_comb begin
    next_busy       = busy;
    next_cyc        = cyc;
    next_units_left = units_left;
    next_done       = 1'b0;
    if (tif.start) begin
      next_busy       = 1'b1;
      next_cyc        = 16'h0001;
      next_units_left = 9'(9'h001 << tif.exp_sel);
    end else if (busy) begin
      if (cyc >= unit_len) begin
        next_cyc = 16'h0001;
        if (units_left == 9'h001) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_units_left = units_left - 9'h001;
        end
      end else begin
        next_cyc = cyc + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy       <= 1'b0;
      cyc        <= 16'h0000;
      units_left <= 9'h000;
      tif.done   <= 1'b0;
    end else begin
      busy       <= next_busy;
      cyc        <= next_cyc;
      units_left <= next_units_left;
      tif.done   <= next_done;
    end
  end
endmodule // ivfr_unit_timer

// ### design/ivfr_top.sv
// Input voltage monitor with programmable limits and the under-voltage fault response.
//
// What this block does
// - Holds a 16-bit linear high-input warning threshold at command 0x57.
// - Threshold at 0x58 is both the low-input warning and hybrid regulation level.
// - Hybrid regulation acts only when enabled by vendor options; otherwise warning only.
// - Holds a 16-bit linear low-input trip threshold at command 0x59.
// - Response 00 keeps the output running through the fault.
// - Response 01 runs for the delay, then follows the retry field if fault remains.
// - Response 10 disables the output at once, then follows the retry field.
// - Response 11 holds the output off while the fault lasts, then re-enables it.
// - Retry field 000 makes no restart; output stays off until faults are cleared.
// - Retry fields 1 to 6 try that many restarts, then latch off until cleared.
// - Restart attempts start one delay apart, delay being two to the field times unit length.
// - Retry field 111 retries forever until commanded off, bias lost or other fault.
// - Delay field value n means two to the n time units, 1 to 128.
// - One delay count sets both the running grace time and restart spacing.
// - Time unit length comes from the vendor timing-unit register, not this byte.
`timescale 1ns/10ps
`include "ivfr_defs.svh"
module ivfr_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_ack,
  output logic             cmd_unsupported,
  input  wire logic [15:0] vin_meas,
  input  wire logic [15:0] delay_unit_cycles,
  input  wire logic        hybrid_ratio_regulation_en,
  input  wire logic        control_pin,
  input  wire logic        operation_on,
  input  wire logic        bias_ok,
  input  wire logic        other_fault_shutdown,
  input  wire logic        clear_faults,
  output logic             output_enable,
  output logic             input_high_warn,
  output logic             input_low_warn,
  output logic             input_low_trip,
  output logic             hybrid_ratio_regulation,
  output logic             trip_latched,
  output ivfr_pkg::ivfr_state_e resp_state
);
  import ivfr_pkg::*;

  // Command registers.
  logic [15:0] input_high_warn_threshold;
  logic [15:0] input_low_warn_threshold;
  logic [15:0] input_low_trip_threshold;
  logic [7:0]  input_low_trip_action;
  logic [15:0] next_high_warn;
  logic [15:0] next_low_warn;
  logic [15:0] next_low_trip;
  logic [7:0]  next_action;
  logic [15:0] next_rdata;
  logic        next_ack;
  logic        next_unsup;

  // Monitor results.
  logic        next_high_flag;
  logic        next_low_flag;
  logic        next_trip_flag;
  logic        next_hybrid;
  ivfr_fix_t   vin_fix;

  // Response sequencer.
  ivfr_state_e state;
  ivfr_state_e next_state;
  logic [2:0]  tries;
  logic [2:0]  next_tries;
  logic        next_out_en;
  logic        control_sync;
  logic        run_cmd;
  ivfr_resp_e  resp;
  logic [2:0]  retry_set;

  ivfr_tmr_if tmr_if ();

  // The control pin comes from outside the clock domain.
  ivfr_sync3 u_ctrl_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (control_pin),
    .dout (control_sync)
  );

  // The unit length arrives from the vendor timing-unit register outside this block.
  ivfr_unit_timer u_timer (
    .clk         (clk),
    .rst         (rst),
    .unit_cycles (delay_unit_cycles),
    .tif         (tmr_if.tmr)
  );

  // Command port: a write stores, a read returns the value; byte registers read zero above.
  always_comb begin
    next_high_warn = input_high_warn_threshold;
    next_low_warn  = input_low_warn_threshold;
    next_low_trip  = input_low_trip_threshold;
    next_action    = input_low_trip_action;
    next_rdata     = cmd_rdata;
    next_ack       = 1'b0;
    next_unsup     = 1'b0;
    if (cmd_valid) begin
      next_ack = 1'b1;
      if (cmd_code == `IVFR_CMD_HIGH_WARN) begin
        next_rdata = input_high_warn_threshold;
        if (cmd_write) begin
          next_high_warn = cmd_wdata;
        end
      end else if (cmd_code == `IVFR_CMD_LOW_WARN) begin
        next_rdata = input_low_warn_threshold;
        if (cmd_write) begin
          next_low_warn = cmd_wdata;
        end
      end else if (cmd_code == `IVFR_CMD_LOW_TRIP) begin
        next_rdata = input_low_trip_threshold;
        if (cmd_write) begin
          next_low_trip = cmd_wdata;
        end
      end else if (cmd_code == `IVFR_CMD_LOW_ACTION) begin
        next_rdata = {8'h00, input_low_trip_action};
        if (cmd_write) begin
          next_action = cmd_wdata[7:0];
        end
      end else begin
        next_ack   = 1'b0;
        next_unsup = 1'b1;
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_high_warn_threshold <= `IVFR_HIGH_WARN_RST;
      input_low_warn_threshold  <= `IVFR_LOW_WARN_RST;
      input_low_trip_threshold  <= `IVFR_LOW_TRIP_RST;
      input_low_trip_action     <= `IVFR_LOW_ACTION_RST;
      cmd_rdata                 <= 16'h0000;
      cmd_ack                   <= 1'b0;
      cmd_unsupported           <= 1'b0;
    end else begin
      input_high_warn_threshold <= next_high_warn;
      input_low_warn_threshold  <= next_low_warn;
      input_low_trip_threshold  <= next_low_trip;
      input_low_trip_action     <= next_action;
      cmd_rdata                 <= next_rdata;
      cmd_ack                   <= next_ack;
      cmd_unsupported           <= next_unsup;
    end
  end

  // Compare in fixed point, so thresholds and samples may use different exponents.
  assign vin_fix = ivfr_lin_to_fix(vin_meas);

  always_comb begin
    next_high_flag = vin_fix > ivfr_lin_to_fix(input_high_warn_threshold);
    next_low_flag  = vin_fix < ivfr_lin_to_fix(input_low_warn_threshold);
    next_trip_flag = vin_fix < ivfr_lin_to_fix(input_low_trip_threshold);
    next_hybrid    = hybrid_ratio_regulation_en && next_low_flag;
  end

  // Flags are registered so the sequencer sees one stable sample per cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_high_warn         <= 1'b0;
      input_low_warn          <= 1'b0;
      input_low_trip          <= 1'b0;
      hybrid_ratio_regulation <= 1'b0;
    end else begin
      input_high_warn         <= next_high_flag;
      input_low_warn          <= next_low_flag;
      input_low_trip          <= next_trip_flag;
      hybrid_ratio_regulation <= next_hybrid;
    end
  end

  // The output may run only while every on-condition holds; any of them drops it, the control pin only after its synchroniser.
  assign run_cmd   = control_sync && operation_on && bias_ok && !other_fault_shutdown;
  assign resp      = ivfr_resp_e'(input_low_trip_action[`IVFR_RESP_MSB:`IVFR_RESP_LSB]);
  assign retry_set = input_low_trip_action[`IVFR_RETRY_MSB:`IVFR_RETRY_LSB];
  assign tmr_if.exp_sel = input_low_trip_action[`IVFR_DELAY_MSB:`IVFR_DELAY_LSB];

  // Fault response sequencer. Each restart attempt starts one delay after the last,
  // and an attempt fails when the trip is still present at its start.
  always_comb begin
    next_state   = state;
    next_tries   = tries;
    tmr_if.start = 1'b0;
    case (state)
      IVFR_ST_OFF: begin
        next_tries = 3'h0;
        if (run_cmd) begin
          next_state = IVFR_ST_RUN;
        end
      end
      IVFR_ST_RUN: begin
        if (input_low_trip) begin
          case (resp)
            IVFR_RESP_IGNORE: begin
              next_state = IVFR_ST_RUN;
            end
            IVFR_RESP_DELAY: begin
              next_state   = IVFR_ST_GRACE;
              tmr_if.start = 1'b1;
            end
            IVFR_RESP_DISABLE: begin
              if (retry_set == `IVFR_RETRY_NONE) begin
                next_state = IVFR_ST_LATCHED;
              end else begin
                next_state   = IVFR_ST_BACKOFF;
                tmr_if.start = 1'b1;
              end
            end
            default: begin
              next_state = IVFR_ST_HOLD;
            end
          endcase
        end
      end
      IVFR_ST_GRACE: begin
        if (tmr_if.done) begin
          if (!input_low_trip) begin
            next_state = IVFR_ST_RUN;
          end else if (retry_set == `IVFR_RETRY_NONE) begin
            next_state = IVFR_ST_LATCHED;
          end else begin
            next_state   = IVFR_ST_BACKOFF;
            tmr_if.start = 1'b1;
          end
        end
      end
      IVFR_ST_BACKOFF: begin
        if (tmr_if.done) begin
          if (!input_low_trip) begin
            next_state = IVFR_ST_RUN;
            next_tries = 3'h0;
          end else if (retry_set == `IVFR_RETRY_FOREVER) begin
            tmr_if.start = 1'b1;
          end else if (tries + 3'h1 >= retry_set) begin
            next_state = IVFR_ST_LATCHED;
          end else begin
            next_tries   = tries + 3'h1;
            tmr_if.start = 1'b1;
          end
        end
      end
      IVFR_ST_HOLD: begin
        if (!input_low_trip) begin
          next_state = IVFR_ST_RUN;
        end
      end
      IVFR_ST_LATCHED: begin
        if (clear_faults) begin
          next_state = IVFR_ST_OFF;
        end
      end
      default: begin
        next_state = IVFR_ST_OFF;
      end
    endcase
    if (!run_cmd) begin
      next_state = IVFR_ST_OFF;
    end
  end

  // Output is driven in running states, including the grace period of the delayed response.
  always_comb begin
    next_out_en = (next_state == IVFR_ST_RUN) || (next_state == IVFR_ST_GRACE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state         <= IVFR_ST_OFF;
      tries         <= 3'h0;
      output_enable <= 1'b0;
    end else begin
      state         <= next_state;
      tries         <= next_tries;
      output_enable <= next_out_en;
    end
  end

  assign trip_latched = (state == IVFR_ST_LATCHED);
  assign resp_state   = state;

endmodule // ivfr_top

// ### dv/ivfr_top_properties.sv
// Concurrent checks on the ports of the input voltage fault response block.
`timescale 1ns/10ps
module ivfr_top_properties
  import ivfr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_ack,
  input wire logic        cmd_unsupported,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] delay_unit_cycles,
  input wire logic        hybrid_ratio_regulation_en,
  input wire logic        control_pin,
  input wire logic        operation_on,
  input wire logic        bias_ok,
  input wire logic        other_fault_shutdown,
  input wire logic        clear_faults,
  input wire logic        output_enable,
  input wire logic        input_high_warn,
  input wire logic        input_low_warn,
  input wire logic        input_low_trip,
  input wire logic        hybrid_ratio_regulation,
  input wire logic        trip_latched,
  input ivfr_state_e      resp_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Commands the block keeps and the conditions that leave the converter wanted on.
  logic supp;
  logic want_on;
  assign supp    = cmd_code inside {8'h57, 8'h58, 8'h59, 8'h5A};
  assign want_on = bias_ok && operation_on && !other_fault_shutdown && control_pin;

  chk_ack_pulse: assert property (cmd_valid && supp |=> cmd_ack && !cmd_unsupported)
    else $error("supported command not acknowledged");
  chk_unsup_zero: assert property (cmd_valid && !supp |=> cmd_unsupported && !cmd_ack && cmd_rdata == 16'h0000)
    else $error("unknown command not refused");
  chk_hybrid_gate: assert property (hybrid_ratio_regulation |-> input_low_warn && $past(hybrid_ratio_regulation_en))
    else $error("hybrid regulation active without enable or low input");
  chk_enable_map: assert property (output_enable == (resp_state inside {IVFR_ST_RUN, IVFR_ST_GRACE}))
    else $error("output enable disagrees with response state");
  chk_latch_flag: assert property (trip_latched == (resp_state == IVFR_ST_LATCHED))
    else $error("latched flag disagrees with state");
  chk_hold_exit: assert property (resp_state == IVFR_ST_HOLD && !input_low_trip |-> ##[1:2] resp_state != IVFR_ST_HOLD)
    else $error("hold kept after fault went away");
  chk_off_cmd: assert property (!bias_ok || other_fault_shutdown || !operation_on |-> ##[1:2] resp_state == IVFR_ST_OFF)
    else $error("converter not off when commanded off");
  chk_latch_stays: assert property (resp_state == IVFR_ST_LATCHED && !clear_faults && want_on |=> resp_state == IVFR_ST_LATCHED)
    else $error("latched state left without clearing");
  chk_no_false_trip: assert property (resp_state == IVFR_ST_RUN && !input_low_trip |=> resp_state inside {IVFR_ST_RUN, IVFR_ST_OFF})
    else $error("fault response started without a trip");

  cover_grace: cover property (resp_state == IVFR_ST_GRACE ##1 resp_state == IVFR_ST_LATCHED);
  cover_resume: cover property (resp_state == IVFR_ST_HOLD ##1 resp_state == IVFR_ST_RUN);
  cover_retry: cover property (resp_state == IVFR_ST_BACKOFF ##1 resp_state == IVFR_ST_RUN);
endmodule // ivfr_top_properties

bind ivfr_top ivfr_top_properties chk (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
  .cmd_unsupported(cmd_unsupported), .vin_meas(vin_meas), .delay_unit_cycles(delay_unit_cycles),
  .hybrid_ratio_regulation_en(hybrid_ratio_regulation_en), .control_pin(control_pin),
  .operation_on(operation_on), .bias_ok(bias_ok), .other_fault_shutdown(other_fault_shutdown),
  .clear_faults(clear_faults), .output_enable(output_enable), .input_high_warn(input_high_warn),
  .input_low_warn(input_low_warn), .input_low_trip(input_low_trip),
  .hybrid_ratio_regulation(hybrid_ratio_regulation), .trip_latched(trip_latched),
  .resp_state(resp_state)
);

// ### dv/ivfr_host_model.sv
// Command host model that issues register commands to the fault response block.
`timescale 1ns/10ps
module ivfr_host_model (
  input  wire logic        clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_unsupported
);
  // Idle bus at time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // The strobe stands for one edge only, since every edge that sees it high is a new command.
  // Write data is inverted once taken, so the block cannot lean on a stale value.
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] d,
                      output logic [15:0] rd, output logic un);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= code;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
    @(negedge clk);
    rd = (cmd_ack || cmd_unsupported) ? cmd_rdata : 16'hxxxx;
    un = cmd_unsupported;
  endtask
endmodule // ivfr_host_model

// ### dv/test_input_voltage_fault_response.sv
// Self-checking bench for the input voltage fault response block.
`timescale 1ns/10ps
`include "ivfr_defs.svh"
module test_input_voltage_fault_response;
  import ivfr_pkg::*;
  logic        clk, rst, cmd_valid, cmd_write, cmd_ack, cmd_unsupported, un;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, rd, vin_meas, delay_unit_cycles;
  logic        hybrid_ratio_regulation_en, control_pin, operation_on, bias_ok;
  logic        other_fault_shutdown, clear_faults, output_enable, trip_latched;
  logic        input_high_warn, input_low_warn, input_low_trip, hybrid_ratio_regulation;
  ivfr_state_e resp_state;
  int          bad_count, checks_done, n;

  ivfr_top dut (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .cmd_unsupported(cmd_unsupported), .vin_meas(vin_meas), .delay_unit_cycles(delay_unit_cycles),
    .hybrid_ratio_regulation_en(hybrid_ratio_regulation_en), .control_pin(control_pin),
    .operation_on(operation_on), .bias_ok(bias_ok), .other_fault_shutdown(other_fault_shutdown),
    .clear_faults(clear_faults), .output_enable(output_enable), .input_high_warn(input_high_warn),
    .input_low_warn(input_low_warn), .input_low_trip(input_low_trip),
    .hybrid_ratio_regulation(hybrid_ratio_regulation), .trip_latched(trip_latched),
    .resp_state(resp_state));
  ivfr_host_model host (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .cmd_unsupported(cmd_unsupported));

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A cycle count inside a window passes as the lower bound; anything else shows itself.
  task automatic cmp_rng(input int cnt, input int lo, input int hi);
    cmp((cnt >= lo && cnt <= hi) ? 16'(lo) : 16'(cnt), 16'(lo));
  endtask

  // Bounded wait for a state; running out of time is a mismatch and ends the run.
  task automatic wait_st(input ivfr_state_e s, input int lim, output int cyc);
    cyc = 0;
    while (resp_state !== s) begin
      @(negedge clk);
      cyc++;
      if (cyc > lim) begin
        cmp({13'h0000, resp_state}, {13'h0000, s});
        final_report();
      end
    end
  endtask

  // The flags answer one edge after the sample, so two edges pass before looking.
  task automatic set_vin(input logic [15:0] v);
    @(posedge clk) vin_meas <= v;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic act(input logic [7:0] a);
    host.xfer(1'b1, 8'h5A, {8'h00, a}, rd, un);
  endtask

  task automatic clear_and_run();
    set_vin(16'h0030);
    @(posedge clk) clear_faults <= 1'b1;
    @(posedge clk) clear_faults <= 1'b0;
    wait_st(IVFR_ST_RUN, 10, n);
  endtask

  // Reset values, write then read back, upper byte of the action and an unknown code.
  task automatic t_regs();
    logic [7:0]  code [4] = '{8'h57, 8'h58, 8'h59, 8'h5A};
    logic [15:0] val  [4] = '{16'h003C, 16'h002D, 16'h0028, 16'hAB12};
    logic [15:0] rst_v[4] = '{`IVFR_HIGH_WARN_RST, `IVFR_LOW_WARN_RST, `IVFR_LOW_TRIP_RST,
                              {8'h00, `IVFR_LOW_ACTION_RST}};
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, code[i], val[i], rd, un);
      cmp(rd, rst_v[i]);
    end
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b0, code[i], 16'h0000, rd, un);
      cmp(rd, (i == 3) ? 16'h0012 : val[i]);
    end
    host.xfer(1'b0, 8'hE0, 16'h0000, rd, un);
    cmp({un, rd[14:0]}, 16'h8000);
  endtask

  // Flags packed as high warn, low warn, hybrid regulation.
  task automatic t_warn();
    @(posedge clk) hybrid_ratio_regulation_en <= 1'b1;
    set_vin(16'h0040);
    cmp({13'h0000, input_high_warn, input_low_warn, hybrid_ratio_regulation}, 16'h0004);
    set_vin(16'h002A);
    cmp({13'h0000, input_high_warn, input_low_warn, hybrid_ratio_regulation}, 16'h0003);
    @(posedge clk) hybrid_ratio_regulation_en <= 1'b0;
    set_vin(16'h002A);
    cmp({13'h0000, input_high_warn, input_low_warn, hybrid_ratio_regulation}, 16'h0002);
    set_vin(16'h0030);
  endtask

  // Ignore keeps running; resume holds off only while the fault lasts.
  task automatic t_ignore_hold();
    act(8'h00);
    set_vin(16'h0020);
    repeat (20) @(negedge clk);
    cmp({12'h000, resp_state, output_enable}, {12'h000, IVFR_ST_RUN, 1'b1});
    act(8'hC0);
    set_vin(16'h0020);
    wait_st(IVFR_ST_HOLD, 4, n);
    cmp({15'h0000, output_enable}, 16'h0000);
    set_vin(16'h0030);
    wait_st(IVFR_ST_RUN, 4, n);
    cmp({15'h0000, output_enable}, 16'h0001);
  endtask

  // Grace length for several delay fields and unit lengths, then no retry latches off.
  task automatic t_grace();
    int d [4] = '{0, 3, 7, 2};
    int u [4] = '{3, 2, 1, 5};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) delay_unit_cycles <= 16'(u[i]);
      act(8'h40 | 8'(d[i]));
      set_vin(16'h0020);
      wait_st(IVFR_ST_GRACE, 3, n);
      cmp({15'h0000, output_enable}, 16'h0001);
      wait_st(IVFR_ST_LATCHED, 400, n);
      cmp_rng(n, (1 << d[i]) * u[i], (1 << d[i]) * u[i] + 3);
      clear_and_run();
    end
    // Delayed response with one retry: a five-cycle grace, a disabled attempt, then latched.
    act(8'h48);
    set_vin(16'h0020);
    wait_st(IVFR_ST_BACKOFF, 20, n);
    cmp_rng(n, 5, 8);
    cmp({15'h0000, output_enable}, 16'h0000);
    wait_st(IVFR_ST_LATCHED, 20, n);
    cmp({15'h0000, trip_latched}, 16'h0001);
    clear_and_run();
  endtask

  // Disable and retry for retry fields 0 to 6; each attempt is one ten-cycle delay apart.
  task automatic t_retry();
    @(posedge clk) delay_unit_cycles <= 16'h000A;
    for (int r = 0; r < 7; r++) begin
      act(8'h80 | 8'(r << 3));
      set_vin(16'h0020);
      wait_st(IVFR_ST_LATCHED, 200, n);
      cmp_rng(n, 10 * r, 11 * r + 3);
      clear_and_run();
    end
    act(8'h98);
    set_vin(16'h0020);
    wait_st(IVFR_ST_BACKOFF, 3, n);
    cmp({15'h0000, output_enable}, 16'h0000);
    set_vin(16'h0030);
    wait_st(IVFR_ST_RUN, 40, n);
    cmp({15'h0000, output_enable}, 16'h0001);
  endtask

  // Endless retry never latches and an off command stops it; the control pin, lost bias and another fault also turn it off.
  task automatic t_forever();
    act(8'hB8);
    set_vin(16'h0020);
    repeat (300) @(negedge clk);
    cmp({15'h0000, trip_latched}, 16'h0000);
    @(posedge clk) operation_on <= 1'b0;
    wait_st(IVFR_ST_OFF, 3, n);
    set_vin(16'h0030);
    @(posedge clk) operation_on <= 1'b1;
    wait_st(IVFR_ST_RUN, 4, n);
    @(posedge clk) control_pin <= 1'b0;
    wait_st(IVFR_ST_OFF, 8, n);
    @(posedge clk) control_pin <= 1'b1;
    wait_st(IVFR_ST_RUN, 8, n);
    cmp({15'h0000, output_enable}, 16'h0001);
    @(posedge clk) bias_ok <= 1'b0;
    wait_st(IVFR_ST_OFF, 3, n);
    cmp({15'h0000, output_enable}, 16'h0000);
    @(posedge clk) bias_ok <= 1'b1;
    wait_st(IVFR_ST_RUN, 4, n);
    @(posedge clk) other_fault_shutdown <= 1'b1;
    wait_st(IVFR_ST_OFF, 3, n);
    cmp({15'h0000, output_enable}, 16'h0000);
    @(posedge clk) other_fault_shutdown <= 1'b0;
    wait_st(IVFR_ST_RUN, 4, n);
    cmp({15'h0000, output_enable}, 16'h0001);
  endtask

  initial begin
    rst = 1'b1;
    vin_meas = 16'h0030;
    delay_unit_cycles = 16'h0002;
    hybrid_ratio_regulation_en = 1'b0;
    control_pin = 1'b1;
    operation_on = 1'b1;
    bias_ok = 1'b1;
    other_fault_shutdown = 1'b0;
    clear_faults = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    wait_st(IVFR_ST_RUN, 10, n);
    t_warn();
    t_ignore_hold();
    t_grace();
    t_retry();
    t_forever();
    final_report();
  end
endmodule // test_input_voltage_fault_response
